// [picchk_assertions.sv]
/* Port checks for picchk_top. Assumes the bind below and one clock domain. */
`timescale 1ns/1ns
module picchk_checker (
  input wire clock,
  input wire arst_n,
  input wire [3:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [31:0] regRdData,
  input wire entryStrobe,
  input wire invalidStateExit,
  input wire entryDone,
  input wire ioRequest,
  input wire ioEarlyFault,
  input wire ioBusy,
  input wire [1:0] ioVerdict,
  input wire ioVerdictValid,
  input wire memRead,
  input wire memBit
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  reg enabled;
  wire take = ioRequest && !ioBusy;
  always @(posedge clock or negedge arst_n)
    if (!arst_n) enabled <= 1'b0;
    else if (regWrite && regAddr == 4'h0) enabled <= regWrData[0];
  AST_ENTRY: assert property (entryStrobe |=> entryDone)
    else $error("entry not acknowledged");
  AST_INVALID: assert property (invalidStateExit |-> $past(entryStrobe))
    else $error("invalid exit without entry");
  AST_OFF: assert property (take && !enabled && !ioEarlyFault |=> ioVerdict == 2'h3)
    else $error("disabled check did not proceed");
  AST_FAULT: assert property (take && ioEarlyFault |=> ioVerdictValid && ioVerdict == 2'h1)
    else $error("early fault not reported first");
  AST_BOUND: assert property (take |-> ##[1:13] ioVerdictValid)
    else $error("verdict late");
  AST_MEM: assert property (memRead |=> !memRead)
    else $error("bitmap read not a pulse");
  AST_RDZERO: assert property (!regRead |=> regRdData == 32'h0)
    else $error("read data outside its cycle");
  AST_IDLE: assert property (ioVerdictValid |-> !ioBusy)
    else $error("busy at verdict");
  AST_EXIT: assert property (ioVerdictValid && ioVerdict == 2'h2 |-> $past(memBit))
    else $error("exit without a set bit");
endmodule // picchk_checker
bind picchk_top picchk_checker u_chk (.*);

// [picchk_defs.vh]
/*
  Constants for the port I/O intercept check: register offsets, exit detail word
  field positions, reset values and encodings. Assumes inclusion by picchk_top.v only.
*/
`ifndef PICCHK_DEFS_VH
`define PICCHK_DEFS_VH

`define PICCHK_REG_CTRL 4'h0
`define PICCHK_REG_BASE_LO 4'h1
`define PICCHK_REG_BASE_HI 4'h2
`define PICCHK_REG_STATUS 4'h3
`define PICCHK_REG_DETAIL 4'h4
`define PICCHK_REG_NEXTIP_LO 4'h5
`define PICCHK_REG_NEXTIP_HI 4'h6
`define PICCHK_REG_MAXPA_LO 4'h7
`define PICCHK_REG_MAXPA_HI 4'h8

`define PICCHK_CTRL_ENABLE 0
`define PICCHK_PAGE_BITS 12
`define PICCHK_BITMAP_LAST 64'h0000_0000_0000_2000
`define PICCHK_LAST_PORT_BITS 17

`define PICCHK_F_PORT_HI 31
`define PICCHK_F_PORT_LO 16
`define PICCHK_F_SEG_HI 12
`define PICCHK_F_SEG_LO 10
`define PICCHK_F_A64 9
`define PICCHK_F_A32 8
`define PICCHK_F_A16 7
`define PICCHK_F_OPERAND_WIDTH_32_FLAG 6
`define PICCHK_F_OPERAND_WIDTH_16_FLAG 5
`define PICCHK_F_SZ8 4
`define PICCHK_F_REP 3
`define PICCHK_F_STR 2
`define PICCHK_F_DIR 0

`define PICCHK_SEG_EXTRA 3'h0
`define PICCHK_ADDR_16 2'h0
`define PICCHK_ADDR_32 2'h1
`define PICCHK_ADDR_64 2'h2
`define PICCHK_OPS_8 2'h0
`define PICCHK_OPS_16 2'h1
`define PICCHK_OPS_32 2'h2
`define PICCHK_BYTES_MAX 3'h4
`define PICCHK_ZERO32 32'h0000_0000
`define PICCHK_ZERO64 64'h0000_0000_0000_0000
`define PICCHK_MAXPA_RESET 64'h0001_0000_0000_0000

`define PICCHK_VERDICT_NONE 2'h0
`define PICCHK_VERDICT_EXCEPT 2'h1
`define PICCHK_VERDICT_EXIT 2'h2
`define PICCHK_VERDICT_PASS 2'h3

`endif

// [picchk_mem_model.sv]
/* Bitmap memory model. Assumes reads come as one-cycle memRead pulses. */
`timescale 1ns/1ns
module picchk_mem_model (
  input wire clock,
  input wire [63:0] base,
  input wire memRead,
  input wire [63:0] memByteAddr,
  input wire [2:0] memBitIndex,
  output reg memBit
);
  // Three bits past port 65535 catch the wrap of a wide access.
  reg perm [0:65538];
  wire [63:0] offset = memByteAddr - base;
  wire [16:0] bitNum = {offset[13:0], memBitIndex};
  integer i;
  initial begin
    for (i = 0; i <= 65538; i = i + 1) perm[i] = 1'b0;
    memBit = 1'b0;
  end
  // Physical addressing; the line toggles between reads so stale data cannot pass.
  always @(posedge clock)
    if (memRead) memBit <= perm[bitNum];
    else memBit <= ~memBit;
endmodule // picchk_mem_model

// [picchk_top.v]
/*
  Port I/O intercept check for guest IN, OUT, INS and OUTS. Holds the loaded bitmap
  base, fetches permission bits one bit every three cycles from a memory read port and
  builds the exit detail word. Assumes memory answers a bit read one cycle later and
  that the core supplies early exception status with each request.
*/
`timescale 1ns/1ns
`include "picchk_defs.vh"

// Notes on behaviour
// - Per-port guest I/O intercept through memory bitmap.
// - Entry loads base, discards low 12 bits.
// - Bitmap end beyond max address: invalid exit.
// - Bitmap bit n governs port n.
// - Bit one intercepts, zero lets access proceed.
// - Bitmap consulted only while enable bit set.
// - Wide access checks every covered port bit.
// - Early exceptions before check, others after.
// - Exit detail word carries port in 31:16.
// - Effective segment number in bits 12:10.
// - One address flag, one operand flag set.
// - Bit 3 marks repeat prefix.
// - Bit 2 marks string port access.
// - Bit 0 direction: one input, zero output.
// - Next instruction pointer saved as second detail.
// - Input string reports extra segment, value zero.
module picchk_top #(
  parameter ADDR_WIDTH = 64
) (
  input wire clock,
  input wire arst_n,
  input wire [3:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regRdData,
  input wire entryStrobe,
  input wire [ADDR_WIDTH-1:0] entryBitmapBase,
  output reg invalidStateExit,
  output reg entryDone,
  input wire ioRequest,
  input wire [15:0] ioPort,
  input wire ioInput,
  input wire ioString,
  input wire ioRepeat,
  input wire [1:0] ioAddrWidth,
  input wire [1:0] ioOperandWidth,
  input wire [2:0] ioSegment,
  input wire [ADDR_WIDTH-1:0] ioNextIp,
  input wire ioEarlyFault,
  output reg ioBusy,
  output reg [1:0] ioVerdict,
  output reg ioVerdictValid,
  output reg memRead,
  output reg [ADDR_WIDTH-1:0] memByteAddr,
  output reg [2:0] memBitIndex,
  input wire memBit
);

  localparam ST_IDLE = 3'b001;
  localparam ST_FETCH = 3'b010;
  localparam ST_WAIT = 3'b100;

  reg [2:0] state;
  reg portInterceptEnable;
  reg [ADDR_WIDTH-1:0] permissionBitmapBase;
  reg [ADDR_WIDTH-1:0] maxPhysAddr;
  reg [31:0] exitDetailWord;
  reg [ADDR_WIDTH-1:0] exitDetailSecond;
  reg [16:0] curPort;
  reg [2:0] bytesLeft;
  reg [31:0] pendWord;
  reg [ADDR_WIDTH-1:0] pendNextIp;
  reg [ADDR_WIDTH-1:0] baseAligned;
  reg [ADDR_WIDTH-1:0] lastByte;
  reg [2:0] byteCount;
  reg [31:0] next_word;
  reg [2:0] effective_selector_index;
  reg [ADDR_WIDTH-1:0] bitAddr;
  reg memBitReady;

  // Base with the page offset dropped, and the address of the bitmap's last byte.
  always @* begin
    baseAligned = {entryBitmapBase[ADDR_WIDTH-1:`PICCHK_PAGE_BITS],
                   {`PICCHK_PAGE_BITS{1'b0}}};
    lastByte = baseAligned + `PICCHK_BITMAP_LAST;
  end

  // Exit detail word built from the request; bits not assigned stay zero.
  always @* begin
    next_word = `PICCHK_ZERO32;
    // Input strings always use the extra segment.
    effective_selector_index = (ioString && ioInput) ? `PICCHK_SEG_EXTRA : ioSegment;
    next_word[`PICCHK_F_PORT_HI:`PICCHK_F_PORT_LO] = ioPort;
    next_word[`PICCHK_F_SEG_HI:`PICCHK_F_SEG_LO] = effective_selector_index;
    next_word[`PICCHK_F_A64] = (ioAddrWidth == `PICCHK_ADDR_64);
    next_word[`PICCHK_F_A32] = (ioAddrWidth == `PICCHK_ADDR_32);
    next_word[`PICCHK_F_A16] = (ioAddrWidth != `PICCHK_ADDR_64) &&
                               (ioAddrWidth != `PICCHK_ADDR_32);
    next_word[`PICCHK_F_OPERAND_WIDTH_32_FLAG] = (ioOperandWidth == `PICCHK_OPS_32);
    next_word[`PICCHK_F_OPERAND_WIDTH_16_FLAG] = (ioOperandWidth == `PICCHK_OPS_16);
    next_word[`PICCHK_F_SZ8] = (ioOperandWidth != `PICCHK_OPS_32) &&
                               (ioOperandWidth != `PICCHK_OPS_16);
    next_word[`PICCHK_F_REP] = ioRepeat;
    next_word[`PICCHK_F_STR] = ioString;
    next_word[`PICCHK_F_DIR] = ioInput;
    case (ioOperandWidth)
      `PICCHK_OPS_32: byteCount = `PICCHK_BYTES_MAX;
      `PICCHK_OPS_16: byteCount = 3'h2;
      default: byteCount = 3'h1;
    endcase
    // Bit n of the map lives at byte n/8, bit n%8.
    bitAddr = permissionBitmapBase + {{(ADDR_WIDTH-14){1'b0}}, curPort[16:3]};
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      portInterceptEnable <= 1'b0;
      permissionBitmapBase <= `PICCHK_ZERO64;
      maxPhysAddr <= `PICCHK_MAXPA_RESET;
      exitDetailWord <= `PICCHK_ZERO32;
      exitDetailSecond <= `PICCHK_ZERO64;
      curPort <= 17'h0_0000;
      bytesLeft <= 3'h0;
      pendWord <= `PICCHK_ZERO32;
      pendNextIp <= `PICCHK_ZERO64;
      regRdData <= `PICCHK_ZERO32;
      invalidStateExit <= 1'b0;
      entryDone <= 1'b0;
      ioBusy <= 1'b0;
      ioVerdict <= `PICCHK_VERDICT_NONE;
      ioVerdictValid <= 1'b0;
      memRead <= 1'b0;
      memByteAddr <= `PICCHK_ZERO64;
      memBitIndex <= 3'h0;
      memBitReady <= 1'b0;
    end else begin
      invalidStateExit <= 1'b0;
      entryDone <= 1'b0;
      ioVerdictValid <= 1'b0;
      memRead <= 1'b0;
      regRdData <= `PICCHK_ZERO32;
      if (regWrite) begin
        case (regAddr)
          `PICCHK_REG_CTRL: portInterceptEnable <= regWrData[`PICCHK_CTRL_ENABLE];
          `PICCHK_REG_MAXPA_LO: maxPhysAddr[31:0] <= regWrData;
          `PICCHK_REG_MAXPA_HI: maxPhysAddr[ADDR_WIDTH-1:32] <= regWrData[ADDR_WIDTH-33:0];
          default: ;
        endcase
      end
      if (regRead) begin
        case (regAddr)
          `PICCHK_REG_CTRL: regRdData <= {31'h0000_0000, portInterceptEnable};
          `PICCHK_REG_BASE_LO: regRdData <= permissionBitmapBase[31:0];
          `PICCHK_REG_BASE_HI: regRdData <= permissionBitmapBase[ADDR_WIDTH-1:32];
          `PICCHK_REG_STATUS: regRdData <= {29'h0000_0000, state};
          `PICCHK_REG_DETAIL: regRdData <= exitDetailWord;
          `PICCHK_REG_NEXTIP_LO: regRdData <= exitDetailSecond[31:0];
          `PICCHK_REG_NEXTIP_HI: regRdData <= exitDetailSecond[ADDR_WIDTH-1:32];
          `PICCHK_REG_MAXPA_LO: regRdData <= maxPhysAddr[31:0];
          `PICCHK_REG_MAXPA_HI: regRdData <= maxPhysAddr[ADDR_WIDTH-1:32];
          default: regRdData <= `PICCHK_ZERO32;
        endcase
      end
      if (entryStrobe) begin
        permissionBitmapBase <= baseAligned;
        entryDone <= 1'b1;
        // The invalid state is reported alongside entryDone; the base is loaded either way.
        invalidStateExit <= (lastByte >= maxPhysAddr);
      end
      case (state)
        ST_IDLE: begin
          if (ioRequest) begin
            pendWord <= next_word;
            pendNextIp <= ioNextIp;
            curPort <= {1'b0, ioPort};
            bytesLeft <= byteCount;
            if (ioEarlyFault) begin
              ioVerdict <= `PICCHK_VERDICT_EXCEPT;
              ioVerdictValid <= 1'b1;
            end else if (!portInterceptEnable) begin
              ioVerdict <= `PICCHK_VERDICT_PASS;
              ioVerdictValid <= 1'b1;
            end else begin
              ioBusy <= 1'b1;
              state <= ST_FETCH;
            end
          end
        end
        ST_FETCH: begin
          memRead <= 1'b1;
          memByteAddr <= bitAddr;
          memBitIndex <= curPort[2:0];
          memBitReady <= 1'b0;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (!memBitReady) begin
            // Memory answers in the cycle after the read pulse, so the bit is not yet valid.
            memBitReady <= 1'b1;
          end else if (memBit) begin
            // Any covered port bit set ends the walk with an exit.
            exitDetailWord <= pendWord;
            exitDetailSecond <= pendNextIp;
            ioVerdict <= `PICCHK_VERDICT_EXIT;
            ioVerdictValid <= 1'b1;
            ioBusy <= 1'b0;
            state <= ST_IDLE;
          end else if (bytesLeft == 3'h1) begin
            // Remaining exceptions are the core's to take after a pass.
            ioVerdict <= `PICCHK_VERDICT_PASS;
            ioVerdictValid <= 1'b1;
            ioBusy <= 1'b0;
            state <= ST_IDLE;
          end else begin
            curPort <= curPort + 17'h0_0001;
            bytesLeft <= bytesLeft - 3'h1;
            state <= ST_FETCH;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // picchk_top

// [tb_top.sv]
/* Bench for picchk_top with the bitmap model. Assumes a 250 MHz clock. */
`timescale 1ns/1ns
module tb_top;
  reg clock = 1'b0;
  reg arst_n = 1'b0;
  reg [3:0] regAddr = 4'h0;
  reg [31:0] regWrData = 32'h0;
  reg regWrite = 1'b0, regRead = 1'b0, entryStrobe = 1'b0, ioRequest = 1'b0;
  reg ioInput = 1'b0, ioString = 1'b0, ioRepeat = 1'b0, ioEarlyFault = 1'b0;
  reg [63:0] entryBitmapBase = 64'h0, ioNextIp = 64'h0, base = 64'h1234_5000;
  reg [15:0] ioPort = 16'h0;
  reg [1:0] ioAddrWidth = 2'h0, ioOperandWidth = 2'h0;
  reg [2:0] ioSegment = 3'h0;
  wire [31:0] regRdData;
  wire invalidStateExit, entryDone, ioBusy, ioVerdictValid, memRead, memBit;
  wire [1:0] ioVerdict;
  wire [63:0] memByteAddr;
  wire [2:0] memBitIndex;
  integer bad_count = 0, comparisons = 0, cycles = 0, reads = 0, r0;
  picchk_top dut (.*);
  picchk_mem_model mem (.*);
  initial forever #2 clock = ~clock;
  task report_and_stop;
    begin
      $display("COUNTS comparisons=%0d mismatches=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (memRead) reads = reads + 1;
    if (cycles == 5000) begin
      bad_count = bad_count + 1;
      report_and_stop;
    end
  end
  task check(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [31:0] exp);
    begin
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 check(regRdData, exp);
    end
  endtask
  task entry(input [63:0] b, input inv);
    begin
      @(posedge clock);
      entryBitmapBase <= b;
      entryStrobe <= 1'b1;
      @(posedge clock);
      entryStrobe <= 1'b0;
      #1 check({30'h0, entryDone, invalidStateExit}, {30'h0, 1'b1, inv});
    end
  endtask
  // The kind field packs fault, input, string, repeat, address and operand width codes.
  task io(input [15:0] p, input [7:0] k, input [2:0] s, input [1:0] v, input [31:0] d);
    integer n;
    begin
      @(posedge clock);
      {ioEarlyFault, ioInput, ioString, ioRepeat, ioAddrWidth, ioOperandWidth} <= k;
      ioPort <= p;
      ioSegment <= s;
      ioNextIp <= {48'h0, p} + 64'h1000;
      ioRequest <= 1'b1;
      @(posedge clock);
      ioRequest <= 1'b0;
      n = 0;
      #1 while (ioVerdictValid !== 1'b1 && n < 16) begin
        @(posedge clock);
        #1 n = n + 1;
      end
      check({29'h0, ioVerdictValid, ioVerdict}, {29'h0, 1'b1, v});
      if (v == 2'h2) begin
        rd(4'h4, d);
        rd(4'h5, {16'h0, p} + 32'h1000);
      end
    end
  endtask
  initial begin
    mem.perm[128] = 1'b1;
    mem.perm[65535] = 1'b1;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    rd(4'h0, 32'h0);
    rd(4'h8, 32'h0001_0000);
    rd(4'hF, 32'h0);
    entry(64'h0000_FFFF_FFFF_E000, 1'b1);
    entry(64'h1234_5ABC, 1'b0);
    rd(4'h1, 32'h1234_5000);
    $display("entry tests done");
    wr(4'h0, 32'h1);
    io(16'h0081, 8'h00, 3'h3, 2'h3, 32'h0);
    io(16'h0080, 8'h40, 3'h3, 2'h2, 32'h0080_0C91);
    io(16'h007D, 8'h36, 3'h3, 2'h2, 32'h007D_0D4C);
    io(16'hFFFF, 8'h79, 3'h5, 2'h2, 32'hFFFF_022D);
    io(16'h007E, 8'h01, 3'h3, 2'h3, 32'h0);
    io(16'h0080, 8'hC0, 3'h3, 2'h1, 32'h0);
    wr(4'h0, 32'h0);
    r0 = reads;
    io(16'h0080, 8'h40, 3'h3, 2'h3, 32'h0);
    check(reads - r0, 32'h0);
    $display("io tests done");
    report_and_stop;
  end
endmodule // tb_top
